// File: rtl/cpu_interrupt_entry.v
// What this block does
// - Source events set read-only status flags
// - Flag requests only when local enable set
// - Maskable requests accepted only with mask clear
// - Reset sets global mask bit
// - Entry starts only at instruction boundary
// - Entry: stack, mask, vector, three fetches
// - Push PC low, PC high, X, A, flags
// - Stack pointer ends below stacked condition codes
// - Saved PC is next main instruction
// - High index byte never saved or restored
// - Return pops reverse, refetches three bytes
// - Return restores mask from stacked flags
// - Highest priority pending source served first
// - Vector high byte at lower address
// - Pin acts only when function enabled
// - Polarity, edge/level, interrupt-or-poll settings
// - Rising polarity selects pull-down
// - Level mode keeps flag set while asserted
// - Synchronous detect, asynchronous stop wake
// - Branch-on-pin instructions see pin level
// - Reset fetches PC vector, fixes stack pointer
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "irq_entry_map.vh"

module cpu_interrupt_entry #(
  parameter NSRC = 14
) (
  input wire mclk,
  input wire rst_b,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [NSRC-1:0] src_event,
  input wire instr_done,
  input wire trap_req,
  input wire rtn_req,
  input wire [15:0] next_pc,
  input wire [7:0] acc_in,
  input wire [7:0] idx_low_in,
  input wire [7:0] mem_rdata,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_wr,
  output reg mem_rd,
  output reg [7:0] fetch_byte,
  output reg fetch_valid,
  output reg [15:0] pc_out,
  output reg [7:0] acc_out,
  output reg [7:0] idx_low_out,
  output reg restore_valid,
  output reg seq_busy,
  output reg seq_done,
  input wire ext_pin,
  input wire stop_mode,
  output reg pull_up_en,
  output reg pull_down_en,
  output reg pin_level,
  output reg stop_wake
);

  // ==========================================================
  // Sequencer states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_PUSH = 6'h02;
  localparam [5:0] ST_VEC = 6'h04;
  localparam [5:0] ST_FILL = 6'h08;
  localparam [5:0] ST_POP = 6'h10;
  localparam [5:0] ST_DONE = 6'h20;

  // Lowest set index, NSRC when none
  function [4:0] first_set;
    input [NSRC-1:0] v;
    integer i;
    begin
      first_set = NSRC[4:0];
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = i[4:0];
        end
      end
    end
  endfunction

  // Vector address of a vector number
  function [15:0] vec_addr;
    input [4:0] num;
    begin
      vec_addr = `RESET_VECTOR - {10'h000, num, 1'b0};
    end
  endfunction

  reg [NSRC-1:0] flags_q;
  reg [NSRC-1:0] enable_q;
  reg [7:0] cond_code_q;
  reg [15:0] stack_ptr_q;
  reg [15:0] pc_q;
  reg [4:0] last_vec_q;
  reg ext_edge_level_q;
  reg ext_ie_q;
  reg ext_pe_q;
  reg ext_pol_q;
  reg ext_flag_q;
  reg pin_s1_q;
  reg pin_s2_q;
  reg asserted_prev_q;
  reg stop_s1_q;
  reg stop_s2_q;
  reg [5:0] state_q;
  reg [2:0] step_q;
  reg phase_q;
  reg [15:0] saved_pc_q;
  reg [7:0] saved_a_q;
  reg [7:0] saved_x_q;
  reg [15:0] fill_base_q;

  wire wr_ok = avs_write & ~avs_waitrequest;
  wire asserted = ext_pe_q & (ext_pol_q ? pin_s2_q : ~pin_s2_q);
  wire ext_edge = asserted & ~asserted_prev_q;
  wire ext_ack = wr_ok && (avs_address == `OFS_EXT_CTRL) && avs_writedata[`EXT_ACK_BIT];
  wire [NSRC-1:0] ext_sel = {{(NSRC-1){1'b0}}, 1'b1} << `EXT_SRC_INDEX;
  wire [NSRC-1:0] all_flags = (flags_q & ~ext_sel) | (ext_sel & {NSRC{ext_flag_q}});
  wire [NSRC-1:0] gate = (enable_q & ~ext_sel) | (ext_sel & {NSRC{ext_ie_q}});
  wire [NSRC-1:0] pending = all_flags & gate;
  wire [4:0] winner = first_set(pending);
  wire req_masked = (|pending) & ~cond_code_q[`COND_MASK_BIT];

  // ==========================================================
  // Avalon slave handshake: one wait cycle per access
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        case (avs_address)
          `OFS_EXT_CTRL: avs_readdata <= {25'h0000000, pin_s2_q, ext_pol_q, ext_pe_q,
                                          ext_flag_q, 1'b0, ext_ie_q, ext_edge_level_q};
          `OFS_SRC_ENABLE: avs_readdata <= {{(32-NSRC){1'b0}}, enable_q};
          `OFS_SRC_FLAGS: avs_readdata <= {{(32-NSRC){1'b0}}, all_flags};
          `OFS_COND_CODE: avs_readdata <= {24'h000000, cond_code_q};
          `OFS_STACK_PTR: avs_readdata <= {16'h0000, stack_ptr_q};
          `OFS_PC: avs_readdata <= {16'h0000, pc_q};
          `OFS_LAST_VEC: avs_readdata <= {27'h0000000, last_vec_q};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Software control registers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= {NSRC{1'b0}};
      ext_edge_level_q <= 1'b0;
      ext_ie_q <= 1'b0;
      ext_pe_q <= 1'b0;
      ext_pol_q <= 1'b0;
    end else if (wr_ok) begin
      if (avs_address == `OFS_SRC_ENABLE) begin
        enable_q <= avs_writedata[NSRC-1:0];
      end
      if (avs_address == `OFS_EXT_CTRL) begin
        ext_edge_level_q <= avs_writedata[`EXT_EDGE_LEVEL_BIT];
        ext_ie_q <= avs_writedata[`EXT_IE_BIT];
        ext_pe_q <= avs_writedata[`EXT_PE_BIT];
        ext_pol_q <= avs_writedata[`EXT_POL_BIT];
      end
    end
  end

  // Peripheral flags: set wins over acknowledge
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= {NSRC{1'b0}};
    end else begin
      if (wr_ok && (avs_address == `OFS_SRC_ACK)) begin
        flags_q <= (flags_q & ~avs_writedata[NSRC-1:0]) | src_event;
      end else begin
        flags_q <= flags_q | src_event;
      end
    end
  end

  // ==========================================================
  // External pin: synchroniser, edge and level detect
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      asserted_prev_q <= 1'b0;
      ext_flag_q <= 1'b0;
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= ext_pin;
      pin_s2_q <= pin_s1_q;
      asserted_prev_q <= asserted;
      stop_s1_q <= stop_mode;
      stop_s2_q <= stop_s1_q;
      if (ext_edge | (ext_edge_level_q & asserted)) begin
        ext_flag_q <= 1'b1;
      end else if (ext_ack | ~ext_pe_q) begin
        ext_flag_q <= 1'b0;
      end
    end
  end

  // Pull selection and pin level for branch instructions
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pull_up_en <= 1'b0;
      pull_down_en <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      pull_up_en <= ext_pe_q & ~ext_pol_q;
      pull_down_en <= ext_pe_q & ext_pol_q;
      pin_level <= ext_pe_q & pin_s2_q;
    end
  end

  // Asynchronous wake in stop mode, cleared once stop is left
  wire wake_trig = ext_pe_q & ext_ie_q & (ext_pol_q ? ext_pin : ~ext_pin);
  wire wake_clr_b = rst_b & stop_s2_q;
  always @(posedge wake_trig or negedge wake_clr_b) begin
    if (!wake_clr_b) begin
      stop_wake <= 1'b0;
    end else begin
      stop_wake <= 1'b1;
    end
  end

  // ==========================================================
  // Entry and return sequencer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_VEC;
      step_q <= 3'h0;
      phase_q <= 1'b0;
      cond_code_q <= `COND_CODE_RESET;
      stack_ptr_q <= `STACK_PTR_RESET;
      pc_q <= `RESET_VECTOR;
      last_vec_q <= 5'h00;
      saved_pc_q <= 16'h0000;
      saved_a_q <= 8'h00;
      saved_x_q <= 8'h00;
      fill_base_q <= 16'h0000;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      fetch_byte <= 8'h00;
      fetch_valid <= 1'b0;
      pc_out <= 16'h0000;
      acc_out <= 8'h00;
      idx_low_out <= 8'h00;
      restore_valid <= 1'b0;
      seq_busy <= 1'b0;
      seq_done <= 1'b0;
    end else begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      fetch_valid <= 1'b0;
      restore_valid <= 1'b0;
      seq_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (wr_ok && (avs_address == `OFS_COND_CODE)) begin
            cond_code_q <= avs_writedata[7:0];
          end
          if (wr_ok && (avs_address == `OFS_STACK_PTR)) begin
            stack_ptr_q <= avs_writedata[15:0];
          end
          if (instr_done & (trap_req | req_masked)) begin
            saved_pc_q <= next_pc;
            saved_a_q <= acc_in;
            saved_x_q <= idx_low_in;
            last_vec_q <= trap_req ? `TRAP_VECTOR_NUM : winner + `SRC_VECTOR_BASE;
            step_q <= 3'h0;
            phase_q <= 1'b0;
            seq_busy <= 1'b1;
            state_q <= ST_PUSH;
          end else if (instr_done & rtn_req) begin
            step_q <= 3'h0;
            phase_q <= 1'b0;
            seq_busy <= 1'b1;
            state_q <= ST_POP;
          end
        end
        ST_PUSH: begin
          mem_wr <= 1'b1;
          mem_addr <= stack_ptr_q;
          case (step_q)
            3'h0: mem_wdata <= saved_pc_q[7:0];
            3'h1: mem_wdata <= saved_pc_q[15:8];
            3'h2: mem_wdata <= saved_x_q;
            3'h3: mem_wdata <= saved_a_q;
            default: mem_wdata <= cond_code_q;
          endcase
          stack_ptr_q <= stack_ptr_q - 16'h0001;
          step_q <= step_q + 3'h1;
          if (step_q == `STACK_BYTES - 3'h1) begin
            cond_code_q[`COND_MASK_BIT] <= 1'b1;
            step_q <= 3'h0;
            state_q <= ST_VEC;
          end
        end
        ST_VEC: begin
          // Two reads: issue, then capture one cycle later; reset fetch too
          seq_busy <= 1'b1;
          phase_q <= ~phase_q;
          if (!phase_q) begin
            mem_rd <= 1'b1;
            mem_addr <= vec_addr(last_vec_q) + {15'h0000, step_q[0]};
          end else begin
            if (step_q[0]) begin
              pc_q[7:0] <= mem_rdata;
              fill_base_q <= {pc_q[15:8], mem_rdata};
              step_q <= 3'h0;
              state_q <= ST_FILL;
            end else begin
              pc_q[15:8] <= mem_rdata;
              step_q <= 3'h1;
            end
          end
        end
        ST_FILL: begin
          phase_q <= ~phase_q;
          if (!phase_q) begin
            mem_rd <= 1'b1;
            mem_addr <= fill_base_q + {13'h0000, step_q};
          end else begin
            fetch_byte <= mem_rdata;
            fetch_valid <= 1'b1;
            step_q <= step_q + 3'h1;
            if (step_q == `FILL_BYTES - 3'h1) begin
              pc_out <= fill_base_q;
              state_q <= ST_DONE;
            end
          end
        end
        ST_POP: begin
          phase_q <= ~phase_q;
          if (!phase_q) begin
            mem_rd <= 1'b1;
            mem_addr <= stack_ptr_q + 16'h0001;
            stack_ptr_q <= stack_ptr_q + 16'h0001;
          end else begin
            case (step_q)
              3'h0: cond_code_q <= mem_rdata;
              3'h1: saved_a_q <= mem_rdata;
              3'h2: saved_x_q <= mem_rdata;
              3'h3: pc_q[15:8] <= mem_rdata;
              default: pc_q[7:0] <= mem_rdata;
            endcase
            step_q <= step_q + 3'h1;
            if (step_q == `STACK_BYTES - 3'h1) begin
              fill_base_q <= {pc_q[15:8], mem_rdata};
              acc_out <= saved_a_q;
              idx_low_out <= saved_x_q;
              restore_valid <= 1'b1;
              step_q <= 3'h0;
              state_q <= ST_FILL;
            end
          end
        end
        ST_DONE: begin
          seq_busy <= 1'b0;
          seq_done <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // cpu_interrupt_entry

// File: rtl/irq_entry_map.vh
`ifndef IRQ_ENTRY_MAP_VH
`define IRQ_ENTRY_MAP_VH

// ==========================================================
// Register byte offsets
`define OFS_EXT_CTRL 5'h00
`define OFS_SRC_ENABLE 5'h04
`define OFS_SRC_FLAGS 5'h08
`define OFS_SRC_ACK 5'h0C
`define OFS_COND_CODE 5'h10
`define OFS_STACK_PTR 5'h14
`define OFS_PC 5'h18
`define OFS_LAST_VEC 5'h1C

// ==========================================================
// External request control fields
`define EXT_EDGE_LEVEL_BIT 0
`define EXT_IE_BIT 1
`define EXT_ACK_BIT 2
`define EXT_FLAG_BIT 3
`define EXT_PE_BIT 4
`define EXT_POL_BIT 5
`define EXT_LEVEL_BIT 6

// ==========================================================
// Condition code mask bit, reset values
`define COND_MASK_BIT 3
`define COND_CODE_RESET 8'h08
`define STACK_PTR_RESET 16'h00FF
`define RESET_VECTOR 16'hFFFE
`define EXT_SRC_INDEX 1
`define TRAP_VECTOR_NUM 5'h01
`define SRC_VECTOR_BASE 5'h02

// ==========================================================
// Sequence counts
`define STACK_BYTES 3'h5
`define FILL_BYTES 3'h3

`endif

// File: test/cpu_interrupt_entry_and_ext_pin_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Bench top
module cpu_interrupt_entry_and_ext_pin_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [13:0] src_event = 14'h0;
  logic instr_done = 1'b0, trap_req = 1'b0, rtn_req = 1'b0, ext_pin = 1'b0, stop_mode = 1'b0;
  logic [15:0] next_pc = 16'h0, pc;
  logic [7:0] acc_in = 8'h00, idx_low_in = 8'h00, cc_exp, ra, rx;
  wire [31:0] avs_readdata;
  wire [15:0] mem_addr, pc_out;
  wire [7:0] mem_rdata, mem_wdata, fetch_byte, acc_out, idx_low_out;
  wire avs_waitrequest, mem_wr, mem_rd, fetch_valid, restore_valid, seq_busy, seq_done;
  wire pull_up_en, pull_down_en, pin_level, stop_wake;
  int error_cnt = 0, compares = 0, j, k, vn;
  logic [31:0] rng = 32'hD242, rd, r, bits;
  logic [15:0] aq[$];
  logic [7:0] wq[$], fq[$], ex[5];
  logic ran;

  cpu_interrupt_entry dut_u (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_event(src_event),
    .instr_done(instr_done), .trap_req(trap_req), .rtn_req(rtn_req), .next_pc(next_pc),
    .acc_in(acc_in), .idx_low_in(idx_low_in), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .fetch_byte(fetch_byte),
    .fetch_valid(fetch_valid), .pc_out(pc_out), .acc_out(acc_out),
    .idx_low_out(idx_low_out), .restore_valid(restore_valid), .seq_busy(seq_busy),
    .seq_done(seq_done), .ext_pin(ext_pin), .stop_mode(stop_mode), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .pin_level(pin_level), .stop_wake(stop_wake));
  mem_partner mem_u (.mclk(mclk), .rst_b(rst_b), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

  // ==========================================================
  // Clock, watchdog, monitor
  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
  always @(posedge mclk) begin
    if (mem_wr === 1'b1) begin
      aq.push_back(mem_addr);
      wq.push_back(mem_wdata);
    end
    if (fetch_valid === 1'b1)
      fq.push_back(fetch_byte);
    if (restore_valid === 1'b1) begin
      ra = acc_out;
      rx = idx_low_out;
    end
  end

  // ==========================================================
  // Helpers
  function logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function logic [7:0] memf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task av(input logic [4:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50)
      error_cnt++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rchk(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    av(a, 1'b0, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task run(input logic t, input logic rt);
    int n;
    n = 0;
    aq.delete();
    wq.delete();
    fq.delete();
    @(posedge mclk);
    instr_done <= 1'b1;
    trap_req <= t;
    rtn_req <= rt;
    @(posedge mclk);
    instr_done <= 1'b0;
    trap_req <= 1'b0;
    rtn_req <= 1'b0;
    while (seq_done !== 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    ran = (n < 60);
  endtask
  task report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    tick(16);
    rst_b <= 1'b1;
    while (seq_done !== 1'b1)
      tick(1);
    pc = {memf(16'hFFFE), memf(16'hFFFF)};
    chk("reset pc", pc, pc_out);
    chk("reset fill", memf(pc), fq[0]);
    rchk("cond code", 5'h10, 32'hFF, 32'h08);
    rchk("stack ptr", 5'h14, 32'hFFFF, 32'h00FF);
    rchk("pc", 5'h18, 32'hFFFF, pc);
    rchk("unmapped", 5'h02, 32'hFFFFFFFF, 32'h0);
    for (int it = 0; it < 4; it++) begin
      r = xs();
      j = (r[3:0] % 14 == 1) ? 3 : r[3:0] % 14;
      k = (r[7:4] % 14 == 1) ? 5 : r[7:4] % 14;
      bits = (it == 0) ? 32'h0 : (32'h1 << j) | (32'h1 << k);
      next_pc <= {1'b1, r[22:8]};
      acc_in <= r[30:23];
      idx_low_in <= r[7:0] ^ 8'hA5;
      cc_exp = (it == 0) ? 8'h08 : 8'h00;
      vn = (it == 0) ? 1 : ((j < k) ? j : k) + 2;
      if (it != 0) begin
        av(5'h04, 1'b1, 32'h0);
        src_event <= bits[13:0];
        tick(1);
        src_event <= 14'h0;
        rchk("flags", 5'h08, 32'h3FFF, bits);
        av(5'h08, 1'b1, 32'h0);
        rchk("flags ro", 5'h08, 32'h3FFF, bits);
        run(1'b0, 1'b0);
        chk("gated", 1'b0, ran);
        av(5'h04, 1'b1, 32'h3FFF);
        av(5'h10, 1'b1, 32'h08);
        run(1'b0, 1'b0);
        chk("masked", 1'b0, ran);
        av(5'h10, 1'b1, 32'h00);
      end
      ex = '{r[15:8], {1'b1, r[22:16]}, r[7:0] ^ 8'hA5, r[30:23], cc_exp};
      pc = {memf(16'hFFFE - 2 * vn), memf(16'hFFFF - 2 * vn)};
      run(it == 0, 1'b0);
      chk("push count", 5, wq.size());
      for (int i = 0; i < 5; i++)
        chk("push", {16'h00FF - i, ex[i]}, {aq[i], wq[i]});
      chk("vector pc", pc, pc_out);
      for (int i = 0; i < 3; i++)
        chk("entry fill", memf(pc + i), fq[i]);
      rchk("stack after", 5'h14, 32'hFFFF, 32'h00FA);
      rchk("mask set", 5'h10, 32'h08, 32'h08);
      rchk("vector", 5'h1C, 32'h1F, vn);
      av(5'h0C, 1'b1, bits);
      run(1'b0, 1'b1);
      chk("ret pc", next_pc, pc_out);
      chk("ret regs", {acc_in, idx_low_in}, {ra, rx});
      for (int i = 0; i < 3; i++)
        chk("ret fill", memf(next_pc + i), fq[i]);
      rchk("cond back", 5'h10, 32'hFF, cc_exp);
      rchk("stack back", 5'h14, 32'hFFFF, 32'h00FF);
    end
    av(5'h00, 1'b1, 32'h31);
    tick(3);
    chk("pull down", 1'b1, pull_down_en);
    ext_pin <= 1'b1;
    tick(4);
    chk("pin level", 1'b1, pin_level);
    av(5'h00, 1'b1, 32'h35);
    rchk("level held", 5'h00, 32'h08, 32'h08);
    ext_pin <= 1'b0;
    tick(4);
    av(5'h00, 1'b1, 32'h35);
    rchk("level clear", 5'h00, 32'h08, 32'h0);
    av(5'h00, 1'b1, 32'h30);
    ext_pin <= 1'b1;
    tick(4);
    rchk("edge flag", 5'h00, 32'h08, 32'h08);
    run(1'b0, 1'b0);
    chk("poll only", 1'b0, ran);
    av(5'h00, 1'b1, 32'h34);
    rchk("edge clear", 5'h00, 32'h08, 32'h0);
    av(5'h00, 1'b1, 32'h20);
    tick(3);
    chk("pin off", 1'b0, pin_level);
    av(5'h00, 1'b1, 32'h10);
    tick(3);
    chk("pull falling", 1'b0, pull_down_en);
    chk("pull up", 1'b1, pull_up_en);
    ext_pin <= 1'b0;
    av(5'h00, 1'b1, 32'h32);
    stop_mode <= 1'b1;
    tick(4);
    ext_pin <= 1'b1;
    tick(4);
    chk("wake", 1'b1, stop_wake);
    ext_pin <= 1'b0;
    stop_mode <= 1'b0;
    tick(5);
    chk("wake clear", 1'b0, stop_wake);
    run(1'b0, 1'b0);
    rchk("ext vector", 5'h1C, 32'h1F, 32'h03);
    report_and_stop();
  end
endmodule // cpu_interrupt_entry_and_ext_pin_bench

// File: test/irq_entry_props.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
module irq_entry_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [15:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic fetch_valid,
  input wire logic seq_busy,
  input wire logic seq_done,
  input wire logic pull_up_en,
  input wire logic pull_down_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Stack burst and vector pair steps
  sequence s_push; mem_wr [*5]; endsequence
  sequence s_vec_pair; mem_rd && !mem_addr[0] ##2 mem_rd; endsequence
  a_wait_drop: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_push_five: assert property ($rose(mem_wr) |-> s_push ##1 !mem_wr)
    else $error("stack burst not five bytes");
  a_push_down: assert property (mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) - 16'h0001)
    else $error("stack address not decrementing");
  a_vec_pair: assert property (mem_wr ##1 !mem_wr |-> s_vec_pair ##0 mem_addr == $past(mem_addr, 2) + 16'h0001)
    else $error("vector fetch pair wrong");
  a_fetch_after: assert property (fetch_valid |-> $past(mem_rd, 1))
    else $error("fetch byte without read");
  a_done_after: assert property (seq_done |-> $past(fetch_valid) && !fetch_valid)
    else $error("done without final fetch");
  a_bus_busy: assert property ((mem_wr || mem_rd) |-> seq_busy)
    else $error("memory cycle outside sequence");
  a_pull_excl: assert property (!(pull_up_en && pull_down_en))
    else $error("both pull devices on");
endmodule // irq_entry_props
bind cpu_interrupt_entry irq_entry_props chk_u (.mclk(mclk), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .fetch_valid(fetch_valid),
  .seq_busy(seq_busy), .seq_done(seq_done), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en));

// File: test/mem_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Memory seen by the core: stack page RAM, pattern elsewhere
module mem_partner (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:255];
  // Stack page writes
  always @(posedge mclk) begin
    if (mem_wr)
      ram[mem_addr[7:0]] <= mem_wdata;
  end
  // Read answer within the strobe cycle, scrambled when idle
  always_comb begin
    if (!rst_b)
      mem_rdata = 8'h00;
    else if (mem_rd && mem_addr[15:8] == 8'h00)
      mem_rdata = ram[mem_addr[7:0]];
    else if (mem_rd)
      mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A;
    else
      mem_rdata = ~(mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A);
  end
endmodule // mem_partner
